// File: gpcfg_consts.svh
`ifndef GPCFG_CONSTS_SVH
`define GPCFG_CONSTS_SVH

// Register indices as printed; byte address is four times the index
`define GPCFG_PIN_IDX 8'h21
`define GPCFG_PATH_IDX 8'h22
`define GPCFG_STAT_IDX 8'h30
`define GPCFG_PIN_ADDR {2'b00, `GPCFG_PIN_IDX, 2'b00}
`define GPCFG_PATH_ADDR {2'b00, `GPCFG_PATH_IDX, 2'b00}
`define GPCFG_STAT_ADDR {2'b00, `GPCFG_STAT_IDX, 2'b00}

// Reset values
`define GPCFG_PIN_RST 8'h00
`define GPCFG_PATH_RST 8'h00

// Pin pair register fields
`define GPCFG_PIN_B_LEVEL 7
`define GPCFG_PIN_B_FAR 6
`define GPCFG_PIN_B_DIR 5
`define GPCFG_PIN_B_FSEL 4
`define GPCFG_PIN_A_LEVEL 3
`define GPCFG_PIN_A_FAR 2
`define GPCFG_PIN_A_DIR 1

// Video and audio path register fields
`define GPCFG_HOLD 7
`define GPCFG_PASS 6
`define GPCFG_POL 5
`define GPCFG_SUPP 4
`define GPCFG_OVR4 3
`define GPCFG_W18 2
`define GPCFG_INBAND 1
`define GPCFG_EN4 0

// Status register fields
`define GPCFG_ST_IN_A 0
`define GPCFG_ST_IN_B 1
`define GPCFG_ST_PROT 2
`define GPCFG_ST_4CH 3

`endif

// File: gpcfg_pkg.sv
package gpcfg_pkg;

  // Pad mode code, written as {direction, function select}
  typedef enum logic [1:0] {
    GPCFG_PAD_FUNC = 2'b00,
    GPCFG_PAD_GPOUT = 2'b01,
    GPCFG_PAD_TRI = 2'b10,
    GPCFG_PAD_GPIN = 2'b11
  } gpcfg_pad_mode_t;

  // Per pin state: synchroniser and registered pad drive
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic pad_out;
    logic pad_oe;
  } gpcfg_pin_state_t;

  // Registered datapath decode outputs
  typedef struct packed {
    logic frame_valid;
    logic prot_en;
    logic audio_pkt_en;
    logic audio_4ch;
    logic video_18;
    logic audio_inband;
    logic valid_low;
  } gpcfg_path_state_t;

  // Register bank and bus answer
  typedef struct packed {
    logic [7:0] pin_cfg;
    logic [7:0] path;
    logic [7:0] rdata;
    logic err;
  } gpcfg_state_t;

endpackage

// File: gpcfg_pin_ctrl.sv
`timescale 1ns/1ps
`include "gpcfg_consts.svh"

module gpcfg_pin_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cfg_level,
  input wire logic cfg_far,
  input wire logic cfg_dir,
  input wire logic cfg_fsel,
  input wire logic far_level,
  input wire logic func_out,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic in_level
);

  gpcfg_pkg::gpcfg_pin_state_t s_q; // All state of the pin
  gpcfg_pkg::gpcfg_pin_state_t s_d; // Next state
  gpcfg_pkg::gpcfg_pad_mode_t mode; // Decoded pad mode

  assign mode = gpcfg_pkg::gpcfg_pad_mode_t'({cfg_dir, cfg_fsel});

  // Pad drive selection and input synchroniser
  always_comb begin
    s_d = s_q;
    // First stage only feeds the second
    s_d.sync1 = pad_in;
    s_d.sync2 = s_q.sync1;
    if (cfg_far) begin
      // Far end owns the pin, forced to output
      s_d.pad_oe = 1'b1;
      s_d.pad_out = far_level;
    end else begin
      case (mode)
        gpcfg_pkg::GPCFG_PAD_FUNC: begin
          s_d.pad_oe = 1'b1;
          s_d.pad_out = func_out;
        end
        gpcfg_pkg::GPCFG_PAD_GPOUT: begin
          s_d.pad_oe = 1'b1;
          s_d.pad_out = cfg_level;
        end
        gpcfg_pkg::GPCFG_PAD_TRI: begin
          s_d.pad_oe = 1'b0;
          s_d.pad_out = 1'b0;
        end
        gpcfg_pkg::GPCFG_PAD_GPIN: begin
          s_d.pad_oe = 1'b0;
          s_d.pad_out = 1'b0;
        end
        default: begin
          s_d.pad_oe = 1'b0;
          s_d.pad_out = 1'b0;
        end
      endcase
    end
  end

  // State register; pad released during reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pad_out = s_q.pad_out;
  assign pad_oe = s_q.pad_oe;
  assign in_level = s_q.sync2;

endmodule

// File: gpcfg_path_decode.sv
`timescale 1ns/1ps
`include "gpcfg_consts.svh"

module gpcfg_path_decode (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] path,
  input wire logic pixel_valid_strobe,
  output logic frame_valid,
  output logic prot_en,
  output logic audio_pkt_en,
  output logic audio_4ch,
  output logic video_18,
  output logic audio_inband,
  output logic valid_low
);

  gpcfg_pkg::gpcfg_path_state_t s_q; // Registered decode
  gpcfg_pkg::gpcfg_path_state_t s_d; // Next value

  // Mode decode of the path register
  always_comb begin
    s_d = s_q;
    if (path[`GPCFG_PASS]) begin
      // Framing ignored, every pixel forwarded
      s_d.frame_valid = 1'b1;
    end else if (path[`GPCFG_POL]) begin
      s_d.frame_valid = ~pixel_valid_strobe;
    end else begin
      s_d.frame_valid = pixel_valid_strobe;
    end
    s_d.prot_en = ~path[`GPCFG_PASS];
    // Pass-through also blocks packet audio
    s_d.audio_pkt_en = ~path[`GPCFG_SUPP] & ~path[`GPCFG_PASS];
    s_d.audio_4ch = path[`GPCFG_OVR4] & path[`GPCFG_EN4];
    s_d.video_18 = path[`GPCFG_W18];
    s_d.audio_inband = path[`GPCFG_INBAND];
    s_d.valid_low = path[`GPCFG_POL];
  end

  // Decode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign frame_valid = s_q.frame_valid;
  assign prot_en = s_q.prot_en;
  assign audio_pkt_en = s_q.audio_pkt_en;
  assign audio_4ch = s_q.audio_4ch;
  assign video_18 = s_q.video_18;
  assign audio_inband = s_q.audio_inband;
  assign valid_low = s_q.valid_low;

endmodule

// File: gpcfg_top.sv
// Overview of operation
// - Local level drives pin in general output mode; pin A never reaches that mode, so its level bit drives nothing
// - Far control forces output of far value
// - Direction and select decode four pad modes; pin A select is tied low, so pin A is functional or tri-state only
// - Hold bit blocks forward-channel path loading
// - Path fields below hold bit follow far end
// - Pass-through forwards pixels ignoring valid strobe
// - Pass-through disables protection, blocks packet audio
// - Suppress bit stops packet audio on pixels
// - Override bit gates four-channel enable bit
// - Width bit selects 18 or 24 bit
// - Transport bit selects in-band or island audio
// - Enable bit switches four-channel audio
// - Path register resets to zero
// - Pin pair register resets to zero
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "gpcfg_consts.svh"

module gpcfg_top (
  // Bus clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Forward channel path update
  input wire logic fc_load_valid,
  input wire logic [6:0] fc_load_fields,
  // Far end pin levels
  input wire logic far_level_a,
  input wire logic far_level_b,
  // Functional drive for each pin
  input wire logic func_out_a,
  input wire logic func_out_b,
  // Pads
  input wire logic pad_in_a,
  input wire logic pad_in_b,
  output logic pad_out_a,
  output logic pad_out_b,
  output logic pad_oe_a,
  output logic pad_oe_b,
  // Video and audio path
  input wire logic pixel_valid_strobe,
  output logic frame_valid,
  output logic prot_en,
  output logic audio_pkt_en,
  output logic audio_4ch_en,
  output logic video_18bit,
  output logic audio_inband,
  output logic valid_active_low
);

  gpcfg_pkg::gpcfg_state_t s_q; // All bank state
  gpcfg_pkg::gpcfg_state_t s_d; // Next state

  // Bus phase decode
  logic setup_ph; // First cycle of a transfer
  logic access_ph; // Completing cycle
  logic wr_take; // Write takes effect this edge
  logic hit_pin; // Pin pair register addressed
  logic hit_path; // Path register addressed
  logic hit_stat; // Status register addressed
  logic hit_any; // Any mapped word
  logic [7:0] stat_val; // Live status byte

  // Per pin configuration vectors, index 0 is pin A
  logic [1:0] cfg_level;
  logic [1:0] cfg_far;
  logic [1:0] cfg_dir;
  logic [1:0] cfg_fsel;
  logic [1:0] far_lvl;
  logic [1:0] func_lvl;
  logic [1:0] pad_in_v;
  logic [1:0] pad_out_v;
  logic [1:0] pad_oe_v;
  logic [1:0] in_lvl;

  // Phases of an APB transfer
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  // Zero wait states, so the access edge is the taking edge
  assign wr_take = access_ph & pwrite & pstrb[0];

  // Full address compare also rejects unaligned addresses
  assign hit_pin = (paddr == `GPCFG_PIN_ADDR);
  assign hit_path = (paddr == `GPCFG_PATH_ADDR);
  assign hit_stat = (paddr == `GPCFG_STAT_ADDR);
  assign hit_any = hit_pin | hit_path | hit_stat;

  // Status byte; upper bits read zero
  always_comb begin
    stat_val = 8'h00;
    stat_val[`GPCFG_ST_IN_A] = in_lvl[0];
    stat_val[`GPCFG_ST_IN_B] = in_lvl[1];
    stat_val[`GPCFG_ST_PROT] = prot_en;
    stat_val[`GPCFG_ST_4CH] = audio_4ch_en;
  end

  // Register bank next state
  always_comb begin
    s_d = s_q;
    // Forward channel loads low fields unless held locally
    if (fc_load_valid && !s_q.path[`GPCFG_HOLD]) begin
      s_d.path[6:0] = fc_load_fields;
    end
    // A software write in the same cycle wins over the load
    if (wr_take) begin
      if (hit_pin) begin
        // Bit 0 is kept but drives nothing
        s_d.pin_cfg = pwdata[7:0];
      end
      if (hit_path) begin
        s_d.path = pwdata[7:0];
      end
    end
    // Read data and error are prepared in the setup cycle
    if (setup_ph) begin
      s_d.err = ~hit_any;
      if (pwrite) begin
        s_d.rdata = 8'h00;
      end else if (hit_pin) begin
        s_d.rdata = s_q.pin_cfg;
      end else if (hit_path) begin
        s_d.rdata = s_q.path;
      end else if (hit_stat) begin
        s_d.rdata = stat_val;
      end else begin
        // Unmapped reads return zero
        s_d.rdata = 8'h00;
      end
    end
  end

  // Bank register; both config bytes clear at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.pin_cfg <= `GPCFG_PIN_RST;
      s_q.path <= `GPCFG_PATH_RST;
      s_q.rdata <= 8'h00;
      s_q.err <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Bus answer; data bits above the byte read zero
  assign prdata = {24'h00_0000, s_q.rdata};
  assign pready = 1'b1;
  assign pslverr = access_ph & s_q.err;

  // Field extraction per pin
  assign cfg_level[0] = s_q.pin_cfg[`GPCFG_PIN_A_LEVEL];
  assign cfg_level[1] = s_q.pin_cfg[`GPCFG_PIN_B_LEVEL];
  assign cfg_far[0] = s_q.pin_cfg[`GPCFG_PIN_A_FAR];
  assign cfg_far[1] = s_q.pin_cfg[`GPCFG_PIN_B_FAR];
  assign cfg_dir[0] = s_q.pin_cfg[`GPCFG_PIN_A_DIR];
  assign cfg_dir[1] = s_q.pin_cfg[`GPCFG_PIN_B_DIR];
  // Pin A has no select bit: functional or tri-state only
  assign cfg_fsel[0] = 1'b0;
  assign cfg_fsel[1] = s_q.pin_cfg[`GPCFG_PIN_B_FSEL];
  assign far_lvl = {far_level_b, far_level_a};
  assign func_lvl = {func_out_b, func_out_a};
  assign pad_in_v = {pad_in_b, pad_in_a};

  // One pad controller per pin
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
      gpcfg_pin_ctrl u_pin (
        .pclk(pclk),
        .presetn(presetn),
        .cfg_level(cfg_level[gi]),
        .cfg_far(cfg_far[gi]),
        .cfg_dir(cfg_dir[gi]),
        .cfg_fsel(cfg_fsel[gi]),
        .far_level(far_lvl[gi]),
        .func_out(func_lvl[gi]),
        .pad_in(pad_in_v[gi]),
        .pad_out(pad_out_v[gi]),
        .pad_oe(pad_oe_v[gi]),
        .in_level(in_lvl[gi])
      );
    end
  endgenerate

  assign pad_out_a = pad_out_v[0];
  assign pad_out_b = pad_out_v[1];
  assign pad_oe_a = pad_oe_v[0];
  assign pad_oe_b = pad_oe_v[1];

  // Path mode decode; outputs lag the register by one cycle
  gpcfg_path_decode u_path (
    .pclk(pclk),
    .presetn(presetn),
    .path(s_q.path),
    .pixel_valid_strobe(pixel_valid_strobe),
    .frame_valid(frame_valid),
    .prot_en(prot_en),
    .audio_pkt_en(audio_pkt_en),
    .audio_4ch(audio_4ch_en),
    .video_18(video_18bit),
    .audio_inband(audio_inband),
    .valid_low(valid_active_low)
  );

endmodule

// File: gpcfg_far_model.sv
`timescale 1ns/1ps
// Far-end serializer: path field loads and pin levels
module gpcfg_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [6:0] fields,
  output logic fc_load_valid,
  output logic [6:0] fc_load_fields,
  output logic far_level_a,
  output logic far_level_b
);
  // Opposite of the functional levels, so a wrong mux shows
  assign far_level_a = 1'b1;
  assign far_level_b = 1'b0;
  // One-cycle load; fields scramble outside the pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fc_load_valid <= 1'b0;
      fc_load_fields <= 7'h00;
    end else begin
      fc_load_valid <= go;
      fc_load_fields <= go ? fields : ~fc_load_fields;
    end
  end
endmodule

// File: gpcfg_monitor.sv
`timescale 1ns/1ps
`include "gpcfg_consts.svh"
// Port-level checks on the config bank
module gpcfg_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pixel_valid_strobe,
  input wire logic pad_out_a,
  input wire logic pad_out_b,
  input wire logic pad_oe_a,
  input wire logic pad_oe_b,
  input wire logic frame_valid,
  input wire logic prot_en,
  input wire logic audio_pkt_en,
  input wire logic valid_active_low
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase of a transfer
  sequence acc_s;
    psel && penable;
  endsequence
  // Address lands on a mapped word
  logic hit;
  assign hit = paddr inside {`GPCFG_PIN_ADDR, `GPCFG_PATH_ADDR, `GPCFG_STAT_ADDR};
  rdy_const_a: assert property (pready) else $error("pready low");
  err_miss_a: assert property (acc_s ##0 !hit |-> pslverr) else $error("no error");
  err_hit_a: assert property (acc_s ##0 hit |-> !pslverr) else $error("false error");
  err_idle_a: assert property (!(psel && penable) |-> !pslverr) else $error("stray error");
  rd_upper_a: assert property (acc_s |-> prdata[31:8] == 24'h00_0000) else $error("upper bits");
  pass_audio_a: assert property (!prot_en |-> !audio_pkt_en) else $error("audio on");
  pass_frame_a: assert property ($past(presetn) && !prot_en |-> frame_valid)
    else $error("valid dropped");
  valid_pol_a: assert property ($past(presetn) && prot_en
    |-> frame_valid == ($past(pixel_valid_strobe) ^ valid_active_low)) else $error("polarity");
  tri_low_a: assert property ((!pad_oe_a -> !pad_out_a) && (!pad_oe_b -> !pad_out_b))
    else $error("undriven pad high");
endmodule
bind gpcfg_top gpcfg_monitor i_gpcfg_monitor (.pclk, .presetn, .psel, .penable, .paddr,
  .prdata, .pready, .pslverr, .pixel_valid_strobe, .pad_out_a, .pad_out_b, .pad_oe_a,
  .pad_oe_b, .frame_valid, .prot_en, .audio_pkt_en, .valid_active_low);

// File: tb_gpio_and_datapath_config.sv
`timescale 1ns/1ps
`include "gpcfg_consts.svh"
// Four-state compare, counted
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_mismatch++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module tb_gpio_and_datapath_config;
  // Row: pin byte, path byte, {oe_a,out_a,oe_b,out_b}, decode outputs
  typedef struct packed {
    logic [7:0] pin;
    logic [7:0] path;
    logic [3:0] pads;
    logic [6:0] dec;
  } gpcfg_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pixel_valid_strobe = 1'b0;
  // Pad A input level, driven so the synchroniser is exercised
  logic pad_in_a = 1'b0;
  // Byte strobes, cleared once to show a masked write stores nothing
  logic [3:0] pstrb = 4'hF;
  // Decode outputs gathered for one compare
  logic [6:0] dec_seen;
  logic go = 1'b0;
  logic [6:0] fields = 7'h00;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, fc_load_valid, far_level_a, far_level_b;
  logic [6:0] fc_load_fields;
  logic pad_out_a, pad_out_b, pad_oe_a, pad_oe_b, frame_valid, prot_en, audio_pkt_en;
  logic audio_4ch_en, video_18bit, audio_inband, valid_active_low;
  int n_mismatch = 0;
  int checked = 0;
  // Functional levels A=0 B=1, far levels A=1 B=0
  gpcfg_row_t rows [10] = '{
    '{8'h00, 8'h00, 4'hB, 7'h30}, '{8'h90, 8'h40, 4'hB, 7'h40},
    '{8'h10, 8'h20, 4'hA, 7'h71}, '{8'h20, 8'h10, 4'h8, 7'h20},
    '{8'hB0, 8'h09, 4'h8, 7'h38}, '{8'h40, 8'h01, 4'hA, 7'h30},
    '{8'h02, 8'h08, 4'h3, 7'h30}, '{8'h0A, 8'h04, 4'h3, 7'h34},
    '{8'h04, 8'h02, 4'hF, 7'h32}, '{8'h01, 8'h06, 4'hB, 7'h36}};

  // Bus clock, 25 ns
  always #12.5 pclk = ~pclk;

  gpcfg_top i_gpcfg_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .fc_load_valid, .fc_load_fields,
    .far_level_a, .far_level_b, .func_out_a(1'b0), .func_out_b(1'b1), .pad_in_a,
    .pad_in_b(1'b0), .pad_out_a, .pad_out_b, .pad_oe_a, .pad_oe_b, .pixel_valid_strobe,
    .frame_valid, .prot_en, .audio_pkt_en, .audio_4ch_en, .video_18bit, .audio_inband,
    .valid_active_low);
  gpcfg_far_model i_gpcfg_far_model (.pclk, .presetn, .go, .fields, .fc_load_valid,
    .fc_load_fields, .far_level_a, .far_level_b);

  // One APB transfer; holds until pready seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Far end pushes one field update, then settle
  task automatic load(input logic [6:0] f);
    @(posedge pclk);
    go <= 1'b1;
    fields <= f;
    @(posedge pclk);
    go <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog, far beyond the roughly 170 cycles needed
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `GPCFG_PIN_ADDR, 8'h00);
    `CHK("pin_rst", 32'h0000_0000, rd)
    apb(1'b0, `GPCFG_PATH_ADDR, 8'h00);
    `CHK("path_rst", 32'h0000_0000, rd)
    foreach (rows[i]) begin
      apb(1'b1, `GPCFG_PIN_ADDR, rows[i].pin);
      apb(1'b1, `GPCFG_PATH_ADDR, rows[i].path);
      repeat (2) @(posedge pclk);
      #1;
      `CHK("pads", rows[i].pads, {pad_oe_a, pad_out_a, pad_oe_b, pad_out_b})
      dec_seen = {frame_valid, prot_en, audio_pkt_en, audio_4ch_en, video_18bit,
        audio_inband, valid_active_low};
      `CHK("dec", rows[i].dec, dec_seen)
      apb(1'b0, `GPCFG_PIN_ADDR, 8'h00);
      `CHK("pin_rd", {24'h00_0000, rows[i].pin}, rd)
    end
    // Hold bit keeps the local value against a far load
    apb(1'b1, `GPCFG_PATH_ADDR, 8'h80);
    load(7'h7F);
    apb(1'b0, `GPCFG_PATH_ADDR, 8'h00);
    `CHK("hold", 32'h0000_0080, rd)
    apb(1'b1, `GPCFG_PATH_ADDR, 8'h00);
    load(7'h4F);
    apb(1'b0, `GPCFG_PATH_ADDR, 8'h00);
    `CHK("load", 32'h0000_004F, rd)
    `CHK("pass", 2'b10, {frame_valid, prot_en})
    // Inverted strobe: high input means idle
    apb(1'b1, `GPCFG_PATH_ADDR, 8'h20);
    pixel_valid_strobe <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    `CHK("strobe", 1'b0, frame_valid)
    // Write with the low byte strobe cleared leaves the path byte alone
    pstrb <= 4'h0;
    apb(1'b1, `GPCFG_PATH_ADDR, 8'h55);
    pstrb <= 4'hF;
    apb(1'b0, `GPCFG_PATH_ADDR, 8'h00);
    `CHK("strb", 32'h0000_0020, rd)
    // Pad A high through two sync stages, protection on, four-channel off
    pad_in_a <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, `GPCFG_STAT_ADDR, 8'h00);
    `CHK("stat", 32'h0000_0005, rd)
    apb(1'b0, 12'h100, 8'h00);
    `CHK("miss", 33'h1_0000_0000, {er, rd})
    // Second reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `GPCFG_PATH_ADDR, 8'h00);
    `CHK("path_rst2", 32'h0000_0000, rd)
    finish_test();
  end
endmodule
